// ### can_gw_pkg.sv
package can_gw_pkg;

  localparam int NUM_OBJ    = 32;
  localparam int NUM_NODE   = 2;
  localparam int NUM_LINE   = 8;
  localparam int ADDR_W     = 12;

  // node register offsets inside a node window
  localparam logic [2:0] NREG_CONTROL  = 3'h0;
  localparam logic [2:0] NREG_TIMING   = 3'h1;
  localparam logic [2:0] NREG_GIRQ_PTR = 3'h2;
  localparam logic [2:0] NREG_IRQ_MASK = 3'h3;
  localparam logic [2:0] NREG_IRQ_PEND = 3'h4;
  // object register offsets inside a 0x20 object window
  localparam logic [2:0] OREG_CONFIG   = 3'h0;
  localparam logic [2:0] OREG_IDENT    = 3'h1;
  localparam logic [2:0] OREG_ACC_MASK = 3'h2;
  localparam logic [2:0] OREG_CONTROL  = 3'h3;
  localparam logic [2:0] OREG_FIFO_GW  = 3'h4;
  localparam logic [2:0] OREG_PAY_LO   = 3'h5;
  localparam logic [2:0] OREG_PAY_HI   = 3'h6;
  // window selectors on paddr[11:10]
  localparam logic [1:0] WIN_NODE      = 2'h0;
  localparam logic [1:0] WIN_OBJ       = 2'h1;

  // two-bit flag codes
  localparam logic [1:0] FLAG_SET      = 2'h2;
  localparam logic [1:0] FLAG_CLR      = 2'h1;

  localparam logic [2:0] FC_SHARED_GW  = 3'h5;

  // reset values
  localparam logic       RST_INIT      = 1'b1;
  localparam logic [28:0] RST_AMASK    = 29'h1FFFFFFF;
  localparam logic [31:0] RST_IMASK    = 32'hFFFFFFFF;

  typedef struct packed {
    logic        node;
    logic        src;
    logic        dir;
    logic        long_identifier_select;
    logic [2:0]  txr;
    logic [2:0]  rxr;
    logic [3:0]  dlc;
    logic [28:0] id;
    logic [28:0] amask;
    logic        ipnd;
    logic        ipdir;
    logic        receive_irq_enable;
    logic        send_irq_enable;
    logic        val;
    logic        fresh;
    logic        upd;
    logic        req;
    logic        rmt;
    logic [2:0]  fc;
    logic        auto_forward_enable;
    logic        remote_forward_enable;
    logic        remote_monitor_enable;
    logic [4:0]  buffer_depth;
    logic [63:0] data;
  } obj_s;

  typedef struct packed {
    logic        init;
    logic        analyzer;
    logic        ie_stat;
    logic        ie_err;
    logic        ie_lec;
    logic [14:0] bt;
    logic [15:0] gip;
    logic [31:0] imask;
    logic        p_err;
    logic        p_lec;
    logic        p_cfc;
    logic        p_stat;
  } node_s;

endpackage : can_gw_pkg

// ### can_gw_objects.sv
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/10ps
// How it works
// - gateway data at source, auto forward: go to destination, store, request send
// - gateway data sent, no remote forward: return to source, clear flags
// - gateway data sent, remote forward: stay, clear request, remote and fresh flags
// - destination remote, no forward: request reply, optional id capture
// - destination remote, forward: move to source, request remote, clear on send
// - gateway data at source, no auto forward: go to destination, no request
// - node init bit blocks all receive and any new transmit start on that node
// - node control picks analyzer mode and enables three irq categories
// - bit timing holds prescaler, jump width and both time segments
// - global pointer routes four node sources to one of eight lines
// - interrupt mask hides masked sources from the pending register
// - thirty-two message objects shared by both nodes
// - node select bit attaches an object to node a or b
// - fifo/gateway register holds function code, route and handover fields
// - long identifier select picks 29-bit or 11-bit compare
// - acceptance mask limits identifier compare to unmasked bits
// - separate send and receive irq enables and routes per object
// - buffer depth field held in the fifo/gateway register
// - host updating: remote frame sets request, reply is held back
// - clearing host updating releases the pending data frame
// - function code 101 makes an object a shared gateway
// - node select clear means source a and destination b
// - source frame while gateway sits at destination is dropped silently
module can_gw_objects
  import can_gw_pkg::*;
(
  // apb slave
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // received frames from each node's protocol engine
  input  wire logic [1:0]            rx_valid,
  input  wire logic [1:0]            rx_remote,
  input  wire logic [1:0]            rx_ext,
  input  wire logic [1:0][28:0]      rx_id,
  input  wire logic [1:0][3:0]       rx_dlc,
  input  wire logic [1:0][63:0]      rx_data,
  // frames offered to each node's protocol engine
  output logic      [1:0]            tx_valid,
  output logic      [1:0]            tx_remote,
  output logic      [1:0]            tx_ext,
  output logic      [1:0][28:0]      tx_id,
  output logic      [1:0][3:0]       tx_dlc,
  output logic      [1:0][63:0]      tx_data,
  input  wire logic [1:0]            tx_done,
  // node events and settings
  input  wire logic [1:0]            node_err_evt,
  input  wire logic [1:0]            node_lec_evt,
  input  wire logic [1:0]            node_cfc_evt,
  input  wire logic [1:0]            node_stat_evt,
  output logic      [1:0]            node_init,
  output logic      [1:0]            node_analyzer,
  output logic      [1:0][14:0]      node_bit_timing,
  // shared interrupt lines
  output logic      [NUM_LINE-1:0]   irq_line
);

  typedef struct packed {
    obj_s  [NUM_OBJ-1:0]  obj;
    node_s [NUM_NODE-1:0] node;
    logic  [1:0]          tx_busy;
    logic  [1:0][4:0]     tx_obj;
    logic  [31:0]         prdata;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic [1:0]      rx_hit;
  logic [1:0][4:0] rx_obj;
  logic [1:0]      tx_cand;
  logic [1:0][4:0] tx_pick;
  logic            wr_acc;

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = 1'b0;
    if (a[11:10] == WIN_NODE)
      ok = (a[9] == 1'b0) && (a[7:5] == 3'h0) && (a[4:2] <= NREG_IRQ_PEND);
    else if (a[11:10] == WIN_OBJ)
      ok = (a[4:2] <= OREG_PAY_HI);
    return ok;
  endfunction : addr_ok

  function automatic logic flag_wr(input logic old, input logic [1:0] code);
    logic r;
    r = old;
    if (code == FLAG_SET) r = 1'b1;
    else if (code == FLAG_CLR) r = 1'b0;
    return r;
  endfunction : flag_wr

  function automatic logic [1:0] flag_rd(input logic b);
    return b ? FLAG_SET : FLAG_CLR;
  endfunction : flag_rd

  function automatic logic is_gw(input obj_s o);
    return o.fc == FC_SHARED_GW;
  endfunction : is_gw

  // data frames go to receive objects, remote frames to transmit objects
  function automatic logic obj_match(input obj_s o, input logic n, input logic rem,
                                     input logic ext, input logic [28:0] id);
    logic [28:0] m;
    m = o.long_identifier_select ? o.amask : {18'h0, o.amask[10:0]};
    return o.val && (o.node == n) && (o.long_identifier_select == ext)
           && (o.dir == rem) && (((id ^ o.id) & m) == 29'h0);
  endfunction : obj_match

  // lowest matching object wins; a gateway away at its destination never
  // matches source traffic, so that frame is dropped with no loss report
  always_comb begin
    for (int n = 0; n < NUM_NODE; n++) begin
      rx_hit[n]  = 1'b0;
      rx_obj[n]  = 5'h0;
      tx_cand[n] = 1'b0;
      tx_pick[n] = 5'h0;
      for (int i = NUM_OBJ - 1; i >= 0; i--) begin
        if (obj_match(state_reg.obj[i], n[0], rx_remote[n], rx_ext[n], rx_id[n])) begin
          rx_hit[n] = 1'b1;
          rx_obj[n] = i[4:0];
        end
        if (state_reg.obj[i].val && state_reg.obj[i].req && state_reg.obj[i].node == n[0]
            && !(state_reg.obj[i].dir && state_reg.obj[i].upd)) begin
          tx_cand[n] = 1'b1;
          tx_pick[n] = i[4:0];
        end
      end
    end
  end

  assign wr_acc = psel && penable && pwrite && addr_ok(paddr);

  always_comb begin
    logic [4:0] oi;
    logic       nn;
    logic [4:0] k;
    state_next = state_reg;
    oi = paddr[9:5];
    nn = paddr[8];
    k  = 5'h0;
    // software writes first so that hardware events below win the same cycle
    if (wr_acc && paddr[11:10] == WIN_NODE) begin
      case (paddr[4:2])
        NREG_CONTROL: begin
          state_next.node[nn].init     = pwdata[0];
          state_next.node[nn].analyzer = pwdata[1];
          state_next.node[nn].ie_stat  = pwdata[2];
          state_next.node[nn].ie_err   = pwdata[3];
          state_next.node[nn].ie_lec   = pwdata[4];
        end
        NREG_TIMING:   state_next.node[nn].bt    = pwdata[14:0];
        NREG_GIRQ_PTR: state_next.node[nn].gip   = pwdata[15:0];
        NREG_IRQ_MASK: state_next.node[nn].imask = pwdata;
        NREG_IRQ_PEND: begin
          if (pwdata[8])  state_next.node[nn].p_err  = 1'b0;
          if (pwdata[9])  state_next.node[nn].p_lec  = 1'b0;
          if (pwdata[10]) state_next.node[nn].p_cfc  = 1'b0;
          if (pwdata[11]) state_next.node[nn].p_stat = 1'b0;
        end
        default: ;
      endcase
    end
    if (wr_acc && paddr[11:10] == WIN_OBJ) begin
      case (paddr[4:2])
        OREG_CONFIG: begin
          state_next.obj[oi].node = pwdata[0];
          state_next.obj[oi].src  = pwdata[0];
          state_next.obj[oi].dir  = pwdata[1];
          state_next.obj[oi].long_identifier_select = pwdata[2];
          state_next.obj[oi].txr  = pwdata[6:4];
          state_next.obj[oi].rxr  = pwdata[10:8];
          state_next.obj[oi].dlc  = pwdata[15:12];
        end
        OREG_IDENT:    state_next.obj[oi].id    = pwdata[28:0];
        OREG_ACC_MASK: state_next.obj[oi].amask = pwdata[28:0];
        OREG_CONTROL: begin
          state_next.obj[oi].ipnd  = flag_wr(state_reg.obj[oi].ipnd,  pwdata[1:0]);
          state_next.obj[oi].receive_irq_enable =
            flag_wr(state_reg.obj[oi].receive_irq_enable, pwdata[3:2]);
          state_next.obj[oi].send_irq_enable =
            flag_wr(state_reg.obj[oi].send_irq_enable, pwdata[5:4]);
          state_next.obj[oi].val   = flag_wr(state_reg.obj[oi].val,   pwdata[7:6]);
          state_next.obj[oi].fresh = flag_wr(state_reg.obj[oi].fresh, pwdata[9:8]);
          state_next.obj[oi].upd   = flag_wr(state_reg.obj[oi].upd,   pwdata[11:10]);
          state_next.obj[oi].req   = flag_wr(state_reg.obj[oi].req,   pwdata[13:12]);
          state_next.obj[oi].rmt   = flag_wr(state_reg.obj[oi].rmt,   pwdata[15:14]);
        end
        OREG_FIFO_GW: begin
          state_next.obj[oi].fc    = pwdata[2:0];
          state_next.obj[oi].auto_forward_enable   = pwdata[3];
          state_next.obj[oi].remote_forward_enable = pwdata[4];
          state_next.obj[oi].remote_monitor_enable = pwdata[5];
          state_next.obj[oi].buffer_depth          = pwdata[12:8];
        end
        OREG_PAY_LO: state_next.obj[oi].data[31:0]  = pwdata;
        OREG_PAY_HI: state_next.obj[oi].data[63:32] = pwdata;
        default: ;
      endcase
    end
    // read data captured in the setup phase, driven in the access phase
    state_next.prdata = 32'h0;
    if (psel && !penable && !pwrite && addr_ok(paddr)) begin
      if (paddr[11:10] == WIN_NODE) begin
        case (paddr[4:2])
          NREG_CONTROL: state_next.prdata = {27'h0, state_reg.node[nn].ie_lec,
            state_reg.node[nn].ie_err, state_reg.node[nn].ie_stat,
            state_reg.node[nn].analyzer, state_reg.node[nn].init};
          NREG_TIMING:   state_next.prdata = {17'h0, state_reg.node[nn].bt};
          NREG_GIRQ_PTR: state_next.prdata = {16'h0, state_reg.node[nn].gip};
          NREG_IRQ_MASK: state_next.prdata = state_reg.node[nn].imask;
          NREG_IRQ_PEND: begin
            for (int i = NUM_OBJ - 1; i >= 0; i--)
              if (state_reg.obj[i].ipnd && state_reg.obj[i].node == nn
                  && state_reg.node[nn].imask[i])
                k = i[4:0];
            state_next.prdata[11:8] = {state_reg.node[nn].p_stat, state_reg.node[nn].p_cfc,
                                      state_reg.node[nn].p_lec, state_reg.node[nn].p_err};
            for (int i = 0; i < NUM_OBJ; i++)
              if (state_reg.obj[i].ipnd && state_reg.obj[i].node == nn
                  && state_reg.node[nn].imask[i] && k == i[4:0])
                state_next.prdata[7:0] = {3'h0, k} + 8'h01;
          end
          default: ;
        endcase
      end else begin
        case (paddr[4:2])
          OREG_CONFIG: state_next.prdata = {16'h0, state_reg.obj[oi].dlc, 1'b0,
            state_reg.obj[oi].rxr, 1'b0, state_reg.obj[oi].txr, 1'b0,
            state_reg.obj[oi].long_identifier_select, state_reg.obj[oi].dir,
            state_reg.obj[oi].node};
          OREG_IDENT:    state_next.prdata = {3'h0, state_reg.obj[oi].id};
          OREG_ACC_MASK: state_next.prdata = {3'h0, state_reg.obj[oi].amask};
          OREG_CONTROL: state_next.prdata = {16'h0, flag_rd(state_reg.obj[oi].rmt),
            flag_rd(state_reg.obj[oi].req), flag_rd(state_reg.obj[oi].upd),
            flag_rd(state_reg.obj[oi].fresh), flag_rd(state_reg.obj[oi].val),
            flag_rd(state_reg.obj[oi].send_irq_enable),
            flag_rd(state_reg.obj[oi].receive_irq_enable),
            flag_rd(state_reg.obj[oi].ipnd)};
          OREG_FIFO_GW: state_next.prdata = {19'h0, state_reg.obj[oi].buffer_depth, 2'h0,
            state_reg.obj[oi].remote_monitor_enable, state_reg.obj[oi].remote_forward_enable,
            state_reg.obj[oi].auto_forward_enable, state_reg.obj[oi].fc};
          OREG_PAY_LO: state_next.prdata = state_reg.obj[oi].data[31:0];
          OREG_PAY_HI: state_next.prdata = state_reg.obj[oi].data[63:32];
          default: ;
        endcase
      end
    end
    for (int n = 0; n < NUM_NODE; n++) begin
      // node sources are sticky until cleared; set wins over clear
      if (node_err_evt[n])  state_next.node[n].p_err  = 1'b1;
      if (node_lec_evt[n])  state_next.node[n].p_lec  = 1'b1;
      if (node_cfc_evt[n])  state_next.node[n].p_cfc  = 1'b1;
      if (node_stat_evt[n]) state_next.node[n].p_stat = 1'b1;
      // transmit completion
      if (state_reg.tx_busy[n] && tx_done[n]) begin
        k = state_reg.tx_obj[n];
        state_next.tx_busy[n] = 1'b0;
        state_next.obj[k].req = 1'b0;
        state_next.obj[k].rmt = 1'b0;
        if (state_reg.obj[k].send_irq_enable) begin
          state_next.obj[k].ipnd  = 1'b1;
          state_next.obj[k].ipdir = 1'b1;
        end
        if (is_gw(state_reg.obj[k]) && state_reg.obj[k].dir) begin
          state_next.obj[k].fresh = 1'b0;
          if (!state_reg.obj[k].remote_forward_enable) begin
            state_next.obj[k].node = state_reg.obj[k].src;
            state_next.obj[k].dir  = 1'b0;
          end
        end
      end else if (!state_reg.tx_busy[n] && tx_cand[n] && !state_reg.node[n].init) begin
        state_next.tx_busy[n] = 1'b1;
        state_next.tx_obj[n]  = tx_pick[n];
      end
      // reception; init blocks all receive, as it blocks new transmit starts above
      if (rx_valid[n] && rx_hit[n] && !state_reg.node[n].init) begin
        k = rx_obj[n];
        if (state_reg.obj[k].receive_irq_enable) begin
          state_next.obj[k].ipnd  = 1'b1;
          state_next.obj[k].ipdir = 1'b0;
        end
        if (!rx_remote[n] || state_reg.obj[k].remote_monitor_enable
            || !is_gw(state_reg.obj[k])) begin
          state_next.obj[k].id  = rx_id[n];
          state_next.obj[k].dlc = rx_dlc[n];
        end
        if (!rx_remote[n]) begin
          state_next.obj[k].data  = rx_data[n];
          state_next.obj[k].fresh = 1'b1;
          state_next.obj[k].rmt   = 1'b0;
          if (is_gw(state_reg.obj[k])) begin
            state_next.obj[k].node = ~state_reg.obj[k].src;
            state_next.obj[k].dir  = 1'b1;
            state_next.obj[k].req  = state_reg.obj[k].auto_forward_enable;
          end
        end else begin
          state_next.obj[k].req = 1'b1;
          state_next.obj[k].rmt = 1'b1;
          if (is_gw(state_reg.obj[k])) begin
            state_next.obj[k].fresh = 1'b0;
            if (state_reg.obj[k].remote_forward_enable) begin
              state_next.obj[k].node  = state_reg.obj[k].src;
              state_next.obj[k].dir   = 1'b0;
              state_next.obj[k].rmt   = 1'b0;
              state_next.obj[k].fresh = state_reg.obj[k].fresh;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      for (int n = 0; n < NUM_NODE; n++) begin
        state_reg.node[n].init  <= RST_INIT;
        state_reg.node[n].imask <= RST_IMASK;
      end
      for (int i = 0; i < NUM_OBJ; i++)
        state_reg.obj[i].amask <= RST_AMASK;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign prdata  = state_reg.prdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);

  always_comb begin
    irq_line = '0;
    for (int n = 0; n < NUM_NODE; n++) begin
      node_init[n]       = state_reg.node[n].init;
      node_analyzer[n]   = state_reg.node[n].analyzer;
      node_bit_timing[n] = state_reg.node[n].bt;
      tx_valid[n]  = state_reg.tx_busy[n];
      tx_remote[n] = !state_reg.obj[state_reg.tx_obj[n]].dir;
      tx_ext[n]    = state_reg.obj[state_reg.tx_obj[n]].long_identifier_select;
      tx_id[n]     = state_reg.obj[state_reg.tx_obj[n]].id;
      tx_dlc[n]    = state_reg.obj[state_reg.tx_obj[n]].dlc;
      tx_data[n]   = state_reg.obj[state_reg.tx_obj[n]].data;
      if (state_reg.node[n].p_err && state_reg.node[n].ie_err)
        irq_line[state_reg.node[n].gip[2:0]] = 1'b1;
      if (state_reg.node[n].p_lec && state_reg.node[n].ie_lec)
        irq_line[state_reg.node[n].gip[6:4]] = 1'b1;
      if (state_reg.node[n].p_stat && state_reg.node[n].ie_stat)
        irq_line[state_reg.node[n].gip[10:8]] = 1'b1;
      if (state_reg.node[n].p_cfc)
        irq_line[state_reg.node[n].gip[14:12]] = 1'b1;
    end
    for (int i = 0; i < NUM_OBJ; i++)
      if (state_reg.obj[i].ipnd)
        irq_line[state_reg.obj[i].ipdir ? state_reg.obj[i].txr
                                        : state_reg.obj[i].rxr] = 1'b1;
  end

  // checks on node a
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [4:0] rxo0;
  logic [4:0] txo0;
  assign rxo0 = rx_obj[0];
  assign txo0 = state_reg.tx_obj[0];

  sequence s_gw_data_rx;
    rx_valid[0] && rx_hit[0] && !rx_remote[0] && !node_init[0]
      && is_gw(state_reg.obj[rxo0]) && !state_reg.obj[rxo0].dir;
  endsequence
  sequence s_gw_remote_rx;
    rx_valid[0] && rx_hit[0] && rx_remote[0] && !node_init[0]
      && is_gw(state_reg.obj[rxo0]) && !(state_reg.tx_busy[0] && tx_done[0]);
  endsequence
  sequence s_gw_data_sent;
    state_reg.tx_busy[0] && tx_done[0] && is_gw(state_reg.obj[txo0])
      && state_reg.obj[txo0].dir && !(rx_valid[0] && rx_hit[0]);
  endsequence

  property p_init_blocks_tx;
    node_init[0] && !tx_valid[0] |=> !tx_valid[0];
  endproperty
  a_init_blocks_tx: assert property (p_init_blocks_tx) else $error("tx started in init");

  property p_gw_fwd;
    s_gw_data_rx ##0 state_reg.obj[rxo0].auto_forward_enable |=>
      state_reg.obj[$past(rxo0)].req
      && state_reg.obj[$past(rxo0)].dir && state_reg.obj[$past(rxo0)].fresh;
  endproperty
  a_gw_fwd: assert property (p_gw_fwd) else $error("gateway did not forward data");

  property p_gw_manual;
    s_gw_data_rx ##0 !state_reg.obj[rxo0].auto_forward_enable |=>
      !state_reg.obj[$past(rxo0)].req
      && state_reg.obj[$past(rxo0)].dir && !state_reg.obj[$past(rxo0)].rmt;
  endproperty
  a_gw_manual: assert property (p_gw_manual) else $error("gateway auto sent");

  property p_gw_return;
    s_gw_data_sent ##0 !state_reg.obj[txo0].remote_forward_enable |=>
      !state_reg.obj[$past(txo0)].dir && !state_reg.obj[$past(txo0)].req
      && state_reg.obj[$past(txo0)].node == state_reg.obj[$past(txo0)].src;
  endproperty
  a_gw_return: assert property (p_gw_return) else $error("gateway did not return");

  property p_gw_stay;
    s_gw_data_sent ##0 state_reg.obj[txo0].remote_forward_enable |=>
      state_reg.obj[$past(txo0)].dir && !state_reg.obj[$past(txo0)].fresh
      && !state_reg.obj[$past(txo0)].req;
  endproperty
  a_gw_stay: assert property (p_gw_stay) else $error("gateway moved after send");

  property p_gw_remote_direct;
    s_gw_remote_rx ##0 !state_reg.obj[rxo0].remote_forward_enable |=>
      state_reg.obj[$past(rxo0)].req
      && state_reg.obj[$past(rxo0)].rmt && !state_reg.obj[$past(rxo0)].fresh;
  endproperty
  a_gw_remote_direct: assert property (p_gw_remote_direct) else $error("bad remote reply");

  property p_gw_remote_fwd;
    s_gw_remote_rx ##0 state_reg.obj[rxo0].remote_forward_enable |=>
      state_reg.obj[$past(rxo0)].req
      && !state_reg.obj[$past(rxo0)].rmt && !state_reg.obj[$past(rxo0)].dir;
  endproperty
  a_gw_remote_fwd: assert property (p_gw_remote_fwd) else $error("remote not forwarded");

  property p_hold_update;
    tx_valid[0] && !$past(tx_valid[0]) && !tx_remote[0] |-> !state_reg.obj[txo0].upd;
  endproperty
  a_hold_update: assert property (p_hold_update) else $error("sent while updating");

endmodule : can_gw_objects

// ### can_bus_model.sv
`timescale 1ns/10ps
module can_bus_model (
  // engine side of both nodes
  input  wire logic             pclk,
  input  wire logic [1:0]       tx_valid,
  output logic      [1:0]       tx_done,
  output logic      [1:0]       rx_valid,
  output logic      [1:0]       rx_remote,
  output logic      [1:0][28:0] rx_id,
  output logic      [1:0][3:0]  rx_dlc,
  output logic      [1:0][63:0] rx_data
);
  int lag = 3;
  int cnt[2];
  initial begin
    {tx_done, rx_valid, rx_remote, rx_id, rx_dlc, rx_data} = '0;
  end
  // a frame takes bus time, so done rises lag+1 clocks after tx_valid rises
  always @(posedge pclk) begin
    for (int n = 0; n < 2; n++) begin
      tx_done[n] <= tx_valid[n] && !tx_done[n] && cnt[n] == lag;
      cnt[n] <= (tx_valid[n] && !tx_done[n]) ? cnt[n] + 1 : 0;
    end
  end
  task send(input int n, input logic r, input logic [28:0] id, input logic [63:0] d);
    @(posedge pclk);
    {rx_valid[n], rx_remote[n], rx_id[n], rx_dlc[n], rx_data[n]} <= {2'b11 & {1'b1, r}, id, 4'h8, d};
    @(posedge pclk);
    // fields go stale after the pulse, not held
    {rx_valid[n], rx_remote[n], rx_id[n], rx_dlc[n], rx_data[n]} <= {1'b0, ~r, ~id, 4'h7, ~d};
  endtask : send
endmodule : can_bus_model

// ### can_shared_gateway_msg_objects_tb.sv
`timescale 1ns/10ps
module can_shared_gateway_msg_objects_tb;
  import can_gw_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, q;
  logic [1:0]       rx_valid, rx_remote, tx_valid, tx_done, tx_remote;
  logic [7:0]       irq_line;
  logic [1:0][28:0] rx_id, tx_id;
  logic [1:0][3:0]  rx_dlc;
  logic [1:0][63:0] rx_data, tx_data;
  int               miscompares, tests_run;
  can_gw_objects i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_remote(rx_remote), .rx_ext(2'b00),
    .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_valid(tx_valid), .tx_remote(tx_remote),
    .tx_ext(), .tx_id(tx_id), .tx_dlc(), .tx_data(tx_data), .tx_done(tx_done),
    .node_err_evt(2'b00), .node_lec_evt(2'b00), .node_cfc_evt(2'b00), .node_stat_evt(2'b00),
    .node_init(), .node_analyzer(), .node_bit_timing(), .irq_line(irq_line));
  can_bus_model i_bus (.pclk(pclk), .tx_valid(tx_valid), .tx_done(tx_done),
    .rx_valid(rx_valid), .rx_remote(rx_remote), .rx_id(rx_id), .rx_dlc(rx_dlc),
    .rx_data(rx_data));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task report_and_stop;
    $display("comparisons %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    if (k >= 50) begin
      miscompares++;
      report_and_stop();
    end
  endtask : apb
  // bounded wait for tx_valid of node n to reach level v
  task wait_tx(input int n, input logic v);
    int k;
    k = 0;
    while (tx_valid[n] !== v && k < 60) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 60) begin
      miscompares++;
      report_and_stop();
    end
  endtask : wait_tx
  task sc_setup;
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h100, 32'h0);
    apb(1, 12'h40C, 32'h40);
    apb(1, 12'h404, 32'h123);
    apb(1, 12'h400, 32'h320);
    apb(1, 12'h410, 32'hD);
    apb(1, 12'h40C, 32'hA8);
  endtask : sc_setup
  task sc_forward;
    i_bus.lag = 25;
    i_bus.send(0, 1'b0, 29'h123, 64'h0123_4567_89AB_CDEF);
    wait_tx(1, 1'b1);
    chk("tx valid", {30'h0, tx_valid}, 32'h2);
    chk("tx id", {3'h0, tx_id[1]}, 32'h123);
    chk("tx data", tx_data[1][63:32], 32'h0123_4567);
    apb(0, 12'h40C, 32'h0);
    chk("flags fwd", q, 32'h66AA);
    chk("irq rx", {24'h0, irq_line}, 32'h8);
    apb(0, 12'h400, 32'h0);
    chk("cfg fwd", {16'h0, q[15:0]}, 32'h8323);
    wait_tx(1, 1'b0);
    apb(0, 12'h40C, 32'h0);
    chk("flags back", q, 32'h55AA);
    chk("irq tx", {24'h0, irq_line}, 32'h4);
    apb(0, 12'h400, 32'h0);
    chk("cfg back", {16'h0, q[15:0]}, 32'h8320);
  endtask : sc_forward
  task sc_init_hold;
    apb(1, 12'h000, 32'h1);
    i_bus.send(0, 1'b0, 29'h123, 64'h5);
    repeat (6) @(posedge pclk);
    chk("held tx", {30'h0, tx_valid}, 32'h0);
    apb(0, 12'h400, 32'h0);
    chk("held cfg", {16'h0, q[15:0]}, 32'h8320);
  endtask : sc_init_hold
  // gateway with source b, so its destination side is node a
  task sc_reverse;
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h42C, 32'h40);
    apb(1, 12'h424, 32'h55);
    apb(1, 12'h420, 32'h1);
    apb(1, 12'h430, 32'h5);
    apb(1, 12'h42C, 32'hA8);
    i_bus.lag = 3;
    i_bus.send(1, 1'b0, 29'h55, 64'h77);
    repeat (4) @(posedge pclk);
    chk("manual tx", {30'h0, tx_valid}, 32'h0);
    i_bus.send(0, 1'b1, 29'h55, 64'h0);
    wait_tx(0, 1'b1);
    chk("reply", {tx_remote[0], tx_data[0][30:0]}, 32'h77);
    wait_tx(0, 1'b0);
    apb(0, 12'h420, 32'h0);
    chk("cfg home", {16'h0, q[15:0]}, 32'h8001);
    apb(1, 12'h430, 32'h1D);
    i_bus.send(1, 1'b0, 29'h55, 64'h78);
    wait_tx(0, 1'b1);
    wait_tx(0, 1'b0);
    apb(0, 12'h420, 32'h0);
    chk("cfg stay", {16'h0, q[15:0]}, 32'h8002);
    i_bus.send(0, 1'b1, 29'h55, 64'h0);
    wait_tx(1, 1'b1);
    chk("remote fwd", {31'h0, tx_remote[1]}, 32'h1);
    wait_tx(1, 1'b0);
    apb(0, 12'h42C, 32'h0);
    chk("flags rmt", q, 32'h55AA);
  endtask : sc_reverse
  task sc_flags;
    apb(1, 12'h40C, 32'h3);
    apb(0, 12'h40C, 32'h0);
    chk("flag keep", q, 32'h55AA);
    apb(1, 12'h40C, 32'h1);
    apb(0, 12'h40C, 32'h0);
    chk("flag clr", q, 32'h55A9);
    apb(0, 12'h0FC, 32'h0);
    chk("unmapped", {q[30:0], e}, 32'h1);
  endtask : sc_flags
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    sc_setup();
    sc_forward();
    sc_init_hold();
    sc_flags();
    sc_reverse();
    report_and_stop();
  end
endmodule : can_shared_gateway_msg_objects_tb
